// ==== inc/phy_ctl_pkg.sv ====
// constants for the phy control and event counter register pair
package phy_ctl_pkg;
	localparam logic [4:0]  CTRL_OFFSET   = 5'h14;
	localparam logic [4:0]  COUNT_OFFSET  = 5'h15;
	localparam logic [15:0] CTRL_RESET    = 16'h8006;
	localparam logic [15:0] CTRL_WR_MASK  = 16'hc11e;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam int          DOWNSHIFT_LSB = 14;
	localparam int          STICKY_BIT    = 8;
	localparam int          RES_LSB       = 3;
	localparam int          SCALING_BIT   = 2;
	localparam int          NEG_PD_BIT    = 1;
	localparam int          SEL_LSB       = 8;
	localparam logic [7:0]  COUNT_MAX     = 8'hff;
	localparam logic [2:0]  LIMIT_TWO     = 3'h2;
	localparam logic [2:0]  LIMIT_THREE   = 3'h3;
	localparam logic [2:0]  LIMIT_FOUR    = 3'h4;
	localparam logic [2:0]  LIMIT_NONE    = 3'h0;

	typedef enum logic [1:0] {
		NO_DOWNSHIFT          = 2'h0,
		DOWNSHIFT_AFTER_TWO   = 2'h1,
		DOWNSHIFT_AFTER_THREE = 2'h2,
		DOWNSHIFT_AFTER_FOUR  = 2'h3
	} speed_downshift_ctrl_e;

	typedef enum logic [3:0] {
		SEL_RX_ERROR   = 4'h0,
		SEL_RX_FRAME   = 4'h1,
		SEL_END_DELIM  = 4'h2,
		SEL_START_DELIM = 4'h3,
		SEL_TX_ERROR   = 4'h4,
		SEL_TX_FRAME   = 4'h5,
		SEL_COLLISION  = 4'h6,
		SEL_LINK_DOWN  = 4'h8,
		SEL_DOWNSHIFT  = 4'h9
	} event_sel_e;
endpackage

// ==== rtl/phy_ctl_regs.sv ====
// phy control register and selectable saturating event counter
`timescale 1ns/10ps
module phy_ctl_regs
	import phy_ctl_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        SOFT_RESET,
	// management register port
	input  wire logic [4:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	output logic             REG_RVALID,
	// events from the datapath
	input  wire logic        RECEIVE_ERROR_EVENT,
	input  wire logic        RECEIVE_FRAME_EVENT,
	input  wire logic        END_DELIMITER_ERROR_EVENT,
	input  wire logic        START_DELIMITER_ERROR_EVENT,
	input  wire logic        TRANSMIT_ERROR_EVENT,
	input  wire logic        TRANSMIT_FRAME_EVENT,
	input  wire logic        COLLISION_EVENT,
	input  wire logic        LINK_DOWN_EVENT,
	input  wire logic        DOWNSHIFT_EVENT,
	// settings to the phy and the event count
	output logic      [1:0]  SPEED_DOWNSHIFT_CTRL,
	output logic      [2:0]  DOWNSHIFT_LIMIT,
	output logic             STICKY_KEEP,
	output logic      [1:0]  CONVERTER_RESOLUTION,
	output logic             QUALITY_POWER_SCALING,
	output logic             NEGOTIATION_POWER_DOWN,
	output logic      [7:0]  EVENT_COUNT
);

	logic [15:0] ctrl;
	logic [3:0]  sel;
	logic [7:0]  count;
	logic [2:0]  limit;

	function automatic logic [2:0] limit_of(input logic [1:0] f);
		case (f)
			DOWNSHIFT_AFTER_TWO:   limit_of = LIMIT_TWO;
			DOWNSHIFT_AFTER_THREE: limit_of = LIMIT_THREE;
			DOWNSHIFT_AFTER_FOUR:  limit_of = LIMIT_FOUR;
			default:               limit_of = LIMIT_NONE;
		endcase
	endfunction

	wire        ctrl_wr   = REG_WR && (REG_ADDR == CTRL_OFFSET);
	wire        count_wr  = REG_WR && (REG_ADDR == COUNT_OFFSET);
	wire        count_rd  = REG_RD && (REG_ADDR == COUNT_OFFSET);
	wire        ctrl_rd   = REG_RD && (REG_ADDR == CTRL_OFFSET);
	wire        keep      = ctrl[STICKY_BIT];
	wire        soft_clr  = SOFT_RESET && !keep;
	wire [15:0] count_reg = {4'h0, sel, count};

	// read-write bits survive a software reset only when sticky is on
	wire [15:0] next_ctrl = soft_clr ? CTRL_RESET :
		ctrl_wr ? (REG_WDATA & CTRL_WR_MASK) : ctrl;
	wire [3:0]  next_sel  = soft_clr ? 4'h0 :
		count_wr ? REG_WDATA[SEL_LSB +: 4] : sel;

	// event inputs laid out by select code; unused codes stay low
	wire [15:0] ev_code;
	wire [15:0] code_hit;

	assign ev_code[SEL_RX_ERROR]    = RECEIVE_ERROR_EVENT;
	assign ev_code[SEL_RX_FRAME]    = RECEIVE_FRAME_EVENT;
	assign ev_code[SEL_END_DELIM]   = END_DELIMITER_ERROR_EVENT;
	assign ev_code[SEL_START_DELIM] = START_DELIMITER_ERROR_EVENT;
	assign ev_code[SEL_TX_ERROR]    = TRANSMIT_ERROR_EVENT;
	assign ev_code[SEL_TX_FRAME]    = TRANSMIT_FRAME_EVENT;
	assign ev_code[SEL_COLLISION]   = COLLISION_EVENT;
	assign ev_code[7]               = 1'b0;
	assign ev_code[SEL_LINK_DOWN]   = LINK_DOWN_EVENT;
	assign ev_code[SEL_DOWNSHIFT]   = DOWNSHIFT_EVENT;
	assign ev_code[15:10]           = 6'h00;

	// one match term per select code
	genvar code;
	generate
		for (code = 0; code < 16; code++) begin : code_g
			assign code_hit[code] = (sel == 4'(code)) && ev_code[code];
		end
	endgenerate

	// receive error and start delimiter counts are approximate under
	// energy saving operation; nothing here corrects them
	wire hit = |code_hit;

	// a clear never swallows an event seen in the same cycle
	wire        count_clr  = count_rd || count_wr || SOFT_RESET;
	wire [7:0]  next_count = count_clr ? {7'h0, hit} :
		(hit && count != COUNT_MAX) ? count + 8'h01 : count;

	// read data is zero outside read cycles so no stale word leaks out
	wire [15:0] next_rdata = ctrl_rd ? ctrl :
		count_rd ? count_reg : 16'h0000;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// select falls back to zero on a software reset without sticky
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sel <= COUNT_RESET[SEL_LSB +: 4];
		end else begin
			sel <= next_sel;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			count <= COUNT_RESET[7:0];
		end else begin
			count <= next_count;
		end
	end

	// limit decodes the next field value so it moves with the field
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			limit <= LIMIT_THREE;
		end else begin
			limit <= limit_of(next_ctrl[DOWNSHIFT_LSB +: 2]);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= 16'h0000;
		end else begin
			REG_RDATA <= next_rdata;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
		end
	end

	assign SPEED_DOWNSHIFT_CTRL   = ctrl[DOWNSHIFT_LSB +: 2];
	assign DOWNSHIFT_LIMIT        = limit;
	assign STICKY_KEEP            = ctrl[STICKY_BIT];
	assign CONVERTER_RESOLUTION   = ctrl[RES_LSB +: 2];
	assign QUALITY_POWER_SCALING  = ctrl[SCALING_BIT];
	assign NEGOTIATION_POWER_DOWN = ctrl[NEG_PD_BIT];
	assign EVENT_COUNT            = count;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	wire plain_ctrl_wr = ctrl_wr && !soft_clr;

	// control register fields
	downshift_map_a: assert property (
		DOWNSHIFT_LIMIT == limit_of(SPEED_DOWNSHIFT_CTRL))
		else $error("downshift limit does not follow field");

	downshift_write_a: assert property (
		plain_ctrl_wr |=> SPEED_DOWNSHIFT_CTRL == $past(REG_WDATA[15:14]))
		else $error("downshift field not written");

	limit_write_a: assert property (
		plain_ctrl_wr |=>
		DOWNSHIFT_LIMIT == limit_of($past(REG_WDATA[15:14])))
		else $error("downshift limit not taken from write");

	limit_none_a: assert property (
		SPEED_DOWNSHIFT_CTRL == NO_DOWNSHIFT |->
		DOWNSHIFT_LIMIT == LIMIT_NONE)
		else $error("downshift limit set while disabled");

	resolution_a: assert property (
		plain_ctrl_wr |=> CONVERTER_RESOLUTION == $past(REG_WDATA[4:3]))
		else $error("resolution field not written");

	scaling_a: assert property (
		plain_ctrl_wr |=> QUALITY_POWER_SCALING == $past(REG_WDATA[2]))
		else $error("power scaling bit not written");

	neg_pd_a: assert property (
		plain_ctrl_wr |=> NEGOTIATION_POWER_DOWN == $past(REG_WDATA[1]))
		else $error("negotiation power-down bit not written");

	sticky_write_a: assert property (
		plain_ctrl_wr |=> STICKY_KEEP == $past(REG_WDATA[8]))
		else $error("sticky bit not written");

	ctrl_hold_a: assert property (
		!ctrl_wr && !soft_clr |=> $stable(ctrl))
		else $error("control changed without a write");

	ctrl_ro_zero_a: assert property (
		(ctrl & ~CTRL_WR_MASK) == 16'h0000)
		else $error("read-only control bit set");

	// software reset
	sticky_keep_a: assert property (
		SOFT_RESET && STICKY_KEEP && !REG_WR |=> $stable(ctrl) && $stable(sel))
		else $error("sticky settings lost on software reset");

	keep_write_a: assert property (
		SOFT_RESET && STICKY_KEEP && ctrl_wr |=>
		ctrl == ($past(REG_WDATA) & CTRL_WR_MASK))
		else $error("write lost under sticky software reset");

	soft_clear_a: assert property (
		SOFT_RESET && !STICKY_KEEP |=> ctrl == CTRL_RESET && sel == 4'h0)
		else $error("software reset left settings in place");

	soft_count_a: assert property (
		SOFT_RESET && !hit |=> EVENT_COUNT == 8'h00)
		else $error("software reset left the count");

	// event counter
	collision_count_a: assert property (
		sel == SEL_COLLISION && COLLISION_EVENT && !count_clr
		&& count != COUNT_MAX |=> EVENT_COUNT == $past(count) + 8'h01)
		else $error("collision not counted");

	generate
		for (code = 0; code < 16; code++) begin : code_chk_g
			code_count_a: assert property (
				sel == 4'(code) && ev_code[code] && !count_clr
				&& count != COUNT_MAX |=> EVENT_COUNT == $past(count) + 8'h01)
				else $error("selected event not counted");
		end
	endgenerate

	unused_code_a: assert property (
		sel == 4'h7 || sel > SEL_DOWNSHIFT |-> !hit)
		else $error("unused select code counted");

	count_inc_a: assert property (
		!hit && !count_clr |=> $stable(EVENT_COUNT))
		else $error("count moved without an event");

	saturate_a: assert property (
		count == COUNT_MAX && !count_clr |=> EVENT_COUNT == COUNT_MAX)
		else $error("count wrapped past its maximum");

	clear_event_a: assert property (
		count_clr && hit |=> EVENT_COUNT == 8'h01)
		else $error("event lost on a clear");

	sel_clear_a: assert property (
		count_wr && !soft_clr |=>
		EVENT_COUNT <= 8'h01 && sel == $past(REG_WDATA[11:8]))
		else $error("select write did not clear the count");

	sel_soft_a: assert property (
		count_wr && soft_clr |=> sel == 4'h0)
		else $error("select write beat the software reset");

	sel_hold_a: assert property (
		!count_wr && !soft_clr |=> $stable(sel))
		else $error("select changed without a write");

	// register reads
	read_clear_a: assert property (
		count_rd && !hit |=> EVENT_COUNT == 8'h00
		&& REG_RDATA[7:0] == $past(count) && REG_RVALID)
		else $error("read did not return then clear the count");

	count_read_a: assert property (
		count_rd |=>
		REG_RDATA[15:12] == 4'h0 && REG_RDATA[11:8] == $past(sel))
		else $error("counter read shows wrong select");

	ctrl_read_a: assert property (
		ctrl_rd |=> REG_RDATA == $past(ctrl))
		else $error("control read returned wrong word");

	reserved_zero_a: assert property (
		ctrl_rd |=> REG_RDATA[13:9] == 5'h00 && REG_RDATA[7:5] == 3'h0
		&& REG_RDATA[0] == 1'b0)
		else $error("reserved control bits read as one");

	rvalid_follow_a: assert property (
		REG_RD |=> REG_RVALID)
		else $error("read not answered");

	rvalid_idle_a: assert property (
		!REG_RD |=> !REG_RVALID && REG_RDATA == 16'h0000)
		else $error("read answer without a read");

	unmapped_read_a: assert property (
		REG_RD && !ctrl_rd && !count_rd |=> REG_RDATA == 16'h0000)
		else $error("unmapped read returned data");

	// main scenarios
	saturation_c: cover property (count == COUNT_MAX ##1 hit);
	read_clear_c: cover property (count != 8'h00 && count_rd);
	sticky_c: cover property (SOFT_RESET && STICKY_KEEP);
	event_on_clear_c: cover property (count_rd && hit);
	ctrl_write_c: cover property (plain_ctrl_wr);
endmodule

// ==== test/mgmt_ctrl_model.sv ====
// management controller model driving the register port of the block
`timescale 1ns/10ps
module mgmt_ctrl_model (
	// clock
	input  wire logic        CLK,
	// register port
	output logic      [4:0]  REG_ADDR,
	output logic             REG_WR,
	output logic      [15:0] REG_WDATA,
	output logic             REG_RD,
	input  wire logic [15:0] REG_RDATA,
	input  wire logic        REG_RVALID
);
	initial begin
		REG_ADDR = 5'h00;
		REG_WR = 1'b0;
		REG_WDATA = 16'h0000;
		REG_RD = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(negedge CLK);
		REG_WR = 1'b0;
		// released data must not keep showing the last word
		REG_WDATA = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(negedge CLK);
		REG_RD = 1'b0;
		v = (REG_RVALID === 1'b1) ? REG_RDATA : 16'hdead;
	endtask
endmodule

// ==== test/phy_control_and_error_counter_tb.sv ====
// self-checking bench for the control register and event counter
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module phy_control_and_error_counter_tb;
	import phy_ctl_pkg::*;
	typedef struct packed {
		logic [3:0] sel;
		logic [3:0] src;
		logic [8:0] n;
		logic [7:0] exp;
	} row_s;
	row_s        rows [11] = '{'{4'h0,0,3,3}, '{4'h1,1,5,5}, '{4'h2,2,1,1},
		'{4'h3,3,2,2}, '{4'h4,4,4,4}, '{4'h5,5,7,7}, '{4'h6,6,2,2},
		'{4'h8,7,3,3}, '{4'h9,8,1,1}, '{4'h1,0,4,0}, '{4'h7,6,2,0}};
	logic [2:0]  lim [4] = '{LIMIT_NONE, LIMIT_TWO, LIMIT_THREE, LIMIT_FOUR};
	logic        CLK = 1'b0, RSTN = 1'b0, SOFT_RESET = 1'b0;
	logic [8:0]  ev = '0;
	logic [4:0]  REG_ADDR;
	logic        REG_WR, REG_RD, REG_RVALID, STICKY_KEEP, QPS, NPD;
	logic [15:0] REG_WDATA, REG_RDATA, v;
	logic [1:0]  SDC, CRES;
	logic [2:0]  DOWNSHIFT_LIMIT;
	logic [7:0]  EVENT_COUNT;
	int          miscompares = 0, total_checks = 0, cycles = 0;
	always #10 CLK = ~CLK;
	mgmt_ctrl_model mgmt_u (.CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID));
	phy_ctl_regs dut_u (.CLK(CLK), .RSTN(RSTN), .SOFT_RESET(SOFT_RESET),
		.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
		.RECEIVE_ERROR_EVENT(ev[0]), .RECEIVE_FRAME_EVENT(ev[1]),
		.END_DELIMITER_ERROR_EVENT(ev[2]), .START_DELIMITER_ERROR_EVENT(ev[3]),
		.TRANSMIT_ERROR_EVENT(ev[4]), .TRANSMIT_FRAME_EVENT(ev[5]),
		.COLLISION_EVENT(ev[6]), .LINK_DOWN_EVENT(ev[7]),
		.DOWNSHIFT_EVENT(ev[8]), .SPEED_DOWNSHIFT_CTRL(SDC),
		.DOWNSHIFT_LIMIT(DOWNSHIFT_LIMIT), .STICKY_KEEP(STICKY_KEEP),
		.CONVERTER_RESOLUTION(CRES), .QUALITY_POWER_SCALING(QPS),
		.NEGOTIATION_POWER_DOWN(NPD), .EVENT_COUNT(EVENT_COUNT));
	task automatic pulse(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge CLK);
			ev[idx] = 1'b1;
		end
		@(negedge CLK);
		ev = '0;
	endtask
	task automatic soft_pulse();
		@(negedge CLK);
		SOFT_RESET = 1'b1;
		@(negedge CLK);
		SOFT_RESET = 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(negedge CLK);
		RSTN = 1'b1;
		mgmt_u.rd(CTRL_OFFSET, v);
		`CHK(v, 16'h8006)
		`CHK(DOWNSHIFT_LIMIT, LIMIT_THREE)
		$display("reset test done");
		foreach (rows[r]) begin
			mgmt_u.wr(COUNT_OFFSET, {4'h0, rows[r].sel, 8'h00});
			pulse(rows[r].src, rows[r].n);
			`CHK(EVENT_COUNT, rows[r].exp)
			mgmt_u.rd(COUNT_OFFSET, v);
			`CHK(v, {4'h0, rows[r].sel, rows[r].exp})
			`CHK(EVENT_COUNT, 8'h00)
			$display("row %0d done", r);
		end
		mgmt_u.wr(COUNT_OFFSET, 16'h0600);
		pulse(6, 300);
		`CHK(EVENT_COUNT, COUNT_MAX)
		mgmt_u.wr(COUNT_OFFSET, 16'h0500);
		`CHK(EVENT_COUNT, 8'h00)
		$display("saturation test done");
		mgmt_u.wr(CTRL_OFFSET, 16'hffff);
		mgmt_u.rd(CTRL_OFFSET, v);
		`CHK(v, CTRL_WR_MASK)
		`CHK({SDC, STICKY_KEEP, CRES, QPS, NPD}, 7'h7f)
		for (int k = 0; k < 4; k++) begin
			mgmt_u.wr(CTRL_OFFSET, {k[1:0], 14'h0008});
			`CHK(DOWNSHIFT_LIMIT, lim[k])
			`CHK({CRES, QPS, NPD}, 4'h4)
		end
		$display("control test done");
		mgmt_u.wr(CTRL_OFFSET, 16'hc100);
		soft_pulse();
		mgmt_u.rd(CTRL_OFFSET, v);
		`CHK(v, 16'hc100)
		mgmt_u.wr(CTRL_OFFSET, 16'h4008);
		soft_pulse();
		mgmt_u.rd(CTRL_OFFSET, v);
		`CHK(v, CTRL_RESET)
		mgmt_u.rd(5'h03, v);
		`CHK(v, 16'h0000)
		$display("soft reset test done");
		complete_run();
	end
endmodule
